// ### tb/rcs_relay_model.sv
// Plug-in module model: detection pins and relay coil counts per slot
`timescale 1ns/1ps
module rcs_relay_model
  import rcs_pkg::*;
(
  // Clock
  input  wire logic      clk_in,
  // Fitted modules chosen by the bench
  input  wire logic [1:0] fit_in,
  input  wire logic [5:0] kind_in,
  // Relay coils from the selector
  input  wire rcs_bank_t relay0_in,
  input  wire rcs_bank_t relay1_in,
  // Detection pins and coil counts
  output logic [1:0]     present_out,
  output logic [5:0]     type_out,
  output int             closed0_out,
  output int             closed1_out
);
  // Pins change on the clock like a slow backplane; empty slots read none
  always_ff @(posedge clk_in) begin
    present_out <= fit_in;
    type_out[2:0] <= fit_in[0] ? kind_in[2:0] : TYPE_NONE;
    type_out[5:3] <= fit_in[1] ? kind_in[5:3] : TYPE_NONE;
  end
  // Energised coils, so the bench can see stray closures at a glance
  always_comb begin
    closed0_out = $countones(relay0_in);
    closed1_out = $countones(relay1_in);
  end
endmodule : rcs_relay_model

// ### tb/rcs_selector_tb.sv
// Self-checking bench for the relay channel selector
`timescale 1ns/1ps
module rcs_selector_tb;
  import rcs_pkg::*;
  logic clk_in = 0, rst_in = 1, key_next_in = 0, key_prev_in = 0;
  logic four_wire_in = 0, req_remote_in = 0;
  logic [1:0] fit = 2'h3;
  logic [5:0] kind = {TYPE_MEAS, TYPE_MEAS};
  rcs_req_s req_in = '0;
  logic [1:0] present;
  logic [5:0] mtype;
  rcs_bank_t relay0_out, relay1_out;
  rcs_chan_s shown_out;
  logic shown_valid_out, no_module_out, no_meas_out, done_out;
  logic [7:0] error_code_out;
  int closed0, closed1, bad_count = 0, tests_run = 0, cycles = 0;
  int ch, s, fw;
  logic done_seen = 1'b0;
  rcs_selector i_dut (.clk_in(clk_in), .rst_in(rst_in),
    .present_in(present), .type_in(mtype), .key_next_in(key_next_in),
    .key_prev_in(key_prev_in), .four_wire_in(four_wire_in),
    .req_in(req_in), .req_remote_in(req_remote_in),
    .relay0_out(relay0_out), .relay1_out(relay1_out),
    .shown_out(shown_out), .shown_valid_out(shown_valid_out),
    .no_module_out(no_module_out),
    .no_measuring_module_indication_out(no_meas_out),
    .error_code_out(error_code_out), .done_out(done_out));
  rcs_relay_model i_model (.clk_in(clk_in), .fit_in(fit), .kind_in(kind),
    .relay0_in(relay0_out), .relay1_in(relay1_out),
    .present_out(present), .type_out(mtype),
    .closed0_out(closed0), .closed1_out(closed1));
  always #10 clk_in = ~clk_in;
  // Cut a hang short well above the expected run length
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 6000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  // Coil image for a selected channel; 4-wire adds pair, sense and pole
  function automatic rcs_bank_t exp_bank(int c, int four);
    rcs_bank_t b = '0;
    if (c == 0) return b;
    b[c-1] = 1'b1;
    b[INPUT_ISO-1] = 1'b1;
    if (four != 0) begin
      b[c+PAIR_OFFSET-1] = 1'b1;
      b[SENSE_ISO-1] = 1'b1;
      b[POLE_RELAY-1] = 1'b1;
    end
    return b;
  endfunction : exp_bank
  task automatic chk_bank(input rcs_bank_t got, input rcs_bank_t exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bank
  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_val
  // Selection state: shown channel and both banks; ch 0 means none
  task automatic chk_sel(input int sl, input int c, input int four);
    chk_val({2'h0, shown_out}, c == 0 ? 8'h00 : 8'((sl << 5) | c));
    chk_val({7'h0, shown_valid_out}, c != 0);
    chk_bank(relay0_out, sl == 0 ? exp_bank(c, four) : '0);
    chk_bank(relay1_out, sl == 1 ? exp_bank(c, four) : '0);
  endtask : chk_sel
  // One remote request, held one cycle, then a bounded wait for done
  task automatic remote(input logic cl, input logic oa, input logic av,
                        input int sd, input int c, input logic [2:0] vt);
    @(posedge clk_in);
    req_in <= '{cl, oa, av, 4'(sd), {4'(c / 10), 4'(c % 10)}, vt};
    req_remote_in <= 1'b1;
    @(posedge clk_in);
    req_remote_in <= 1'b0;
    req_in <= '0;
    done_seen = 1'b0;
    for (int i = 0; i < 10; i++) begin
      #1;
      if (done_out === 1'b1) begin
        done_seen = 1'b1;
        break;
      end
      @(posedge clk_in);
    end
    repeat (2) @(posedge clk_in);
    #1;
  endtask : remote
  // Step key press; the pin passes a synchroniser before it acts
  task automatic press(input logic nxt);
    @(posedge clk_in);
    key_next_in <= nxt;
    key_prev_in <= ~nxt;
    repeat (4) @(posedge clk_in);
    key_next_in <= 1'b0;
    key_prev_in <= 1'b0;
    repeat (10) @(posedge clk_in);
    #1;
  endtask : press
  task automatic pins(input logic [1:0] f, input logic [5:0] k);
    @(posedge clk_in);
    fit <= f;
    kind <= k;
    repeat (6) @(posedge clk_in);
  endtask : pins
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish
  initial begin
    void'($urandom(92101));
    repeat (10) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    #1;
    chk_sel(0, 0, 0);
    // Random selections over both slots and both wiring modes
    for (int n = 0; n < 12; n++) begin
      fw = $urandom_range(1);
      s = $urandom_range(1);
      ch = fw ? $urandom_range(SYS_CH_MAX, 1) : $urandom_range(MEAS_CH, 1);
      if (n < 2) ch = (n == 0) ? 1 : (fw ? SYS_CH_MAX : MEAS_CH);
      @(posedge clk_in);
      four_wire_in <= fw[0];
      remote(1'b1, 1'b0, 1'b0, s + 1, ch, 3'h0);
      chk_sel(s, ch, fw);
      chk_val(error_code_out, ERR_NONE);
      chk_val(8'(closed0 + closed1), fw ? 8'h05 : 8'h02);
      chk_val({7'h0, done_seen}, 8'h01);
    end
    // Paired channel and isolation relay refused in 4-wire
    @(posedge clk_in);
    four_wire_in <= 1'b1;
    remote(1'b1, 1'b0, 1'b0, 1, 4, 3'h0);
    remote(1'b1, 1'b0, 1'b0, 1, 12, 3'h0);
    chk_val(error_code_out, ERR_RANGE);
    chk_sel(0, 4, 1);
    remote(1'b1, 1'b0, 1'b0, 2, 25, 3'h0);
    chk_val(error_code_out, ERR_RANGE);
    remote(1'b0, 1'b1, 1'b0, 1, 0, 3'h0);
    chk_sel(0, 0, 0);
    chk_val(error_code_out, ERR_NONE);
    // Step keys in 2-wire with slot 2 empty, then past the top end
    @(posedge clk_in);
    four_wire_in <= 1'b0;
    pins(2'h1, {TYPE_NONE, TYPE_MEAS});
    remote(1'b1, 1'b0, 1'b0, 1, 5, 3'h0);
    press(1'b1);
    chk_sel(0, 6, 0);
    press(1'b0);
    press(1'b0);
    chk_sel(0, 4, 0);
    remote(1'b1, 1'b0, 1'b0, 1, MEAS_CH, 3'h0);
    press(1'b1);
    chk_sel(0, 0, 0);
    // No module fitted, then only a non-measuring module
    pins(2'h0, 6'h00);
    press(1'b1);
    chk_val({7'h0, no_module_out}, 8'h01);
    chk_sel(0, 0, 0);
    pins(2'h1, {TYPE_NONE, TYPE_NONMEAS});
    press(1'b0);
    chk_val({7'h0, no_meas_out}, 8'h01);
    chk_sel(0, 0, 0);
    // Virtual module: refused on a fitted slot, accepted on an empty one
    remote(1'b0, 1'b0, 1'b1, 1, 0, TYPE_MEAS);
    remote(1'b1, 1'b0, 1'b0, 1, 3, 3'h0);
    chk_val(error_code_out, ERR_RANGE);
    remote(1'b0, 1'b0, 1'b1, 2, 0, TYPE_MEAS);
    remote(1'b1, 1'b0, 1'b0, 2, 3, 3'h0);
    chk_sel(1, 3, 0);
    chk_val(error_code_out, ERR_NONE);
    // Empty slot 1 now: the refused assignment must not have stuck
    pins(2'h0, 6'h00);
    remote(1'b1, 1'b0, 1'b0, 1, 3, 3'h0);
    chk_val(error_code_out, ERR_RANGE);
    // Reset stands in for power loss: the virtual module is gone
    @(posedge clk_in);
    rst_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    #1;
    chk_sel(0, 0, 0);
    remote(1'b1, 1'b0, 1'b0, 2, 3, 3'h0);
    chk_val(error_code_out, ERR_RANGE);
    chk_sel(0, 0, 0);
    tally_and_finish();
  end
endmodule : rcs_selector_tb

// ### verilog/rcs_code_decode.sv
// Decoder of a three-digit slot-plus-channel code
`timescale 1ns/1ps
module rcs_code_decode (
  // Code digits
  input  wire logic [3:0] slot_digit_in,
  input  wire logic [7:0] chan_bcd_in,
  // Decoded channel
  output logic            ok_out,
  output rcs_pkg::rcs_chan_s chan_out
);
  import rcs_pkg::*;
  logic [4:0] bin;

  // BCD to binary; tens digit above 2 can never be a channel
  always_comb begin
    bin = 5'(chan_bcd_in[3:0]) + 5'(chan_bcd_in[7:4]) * 5'h0A;
    ok_out = (slot_digit_in == 4'h1 || slot_digit_in == 4'h2) &&
             chan_bcd_in[7:4] < 4'h3 && chan_bcd_in[3:0] < 4'hA; // [R5]
    chan_out.slot = (slot_digit_in == 4'h2);
    chan_out.chan = bin;
  end
endmodule : rcs_code_decode

// ### verilog/rcs_msg_timer.sv
// Brief indication timer for front-panel messages
`timescale 1ns/1ps
module rcs_msg_timer (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rst_in,
  // Trigger and indication
  input  wire logic start_in,
  output logic      busy_out
);
  import rcs_pkg::*;
  logic [31:0] cnt_reg;

  // Restart on each trigger so a repeated press extends the message
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cnt_reg <= 32'h0;
    end else if (start_in) begin
      cnt_reg <= 32'(MSG_CYCLES);
    end else if (cnt_reg != 32'h0) begin
      cnt_reg <= cnt_reg - 32'h1;
    end
  end
  assign busy_out = (cnt_reg != 32'h0);
endmodule : rcs_msg_timer

// ### verilog/rcs_pkg.sv
// Package of constants and types for the relay channel selector
package rcs_pkg;
  localparam int unsigned NUM_SLOTS      = 2;
  localparam int unsigned NUM_RELAYS     = 25;   // Relay positions per module
  localparam int unsigned MEAS_CH        = 20;   // Measurement channels
  localparam int unsigned PAIR_OFFSET    = 10;   // Channel n pairs with n+10
  localparam int unsigned SYS_CH_MAX     = 10;   // Highest 4-wire system ch
  localparam logic [4:0]  POLE_RELAY     = 5'h17; // Relay 23
  localparam logic [4:0]  SENSE_ISO      = 5'h18; // Relay 24
  localparam logic [4:0]  INPUT_ISO      = 5'h19; // Relay 25
  localparam logic [7:0]  ERR_RANGE      = 8'hDE; // Error -222 as 8-bit code 222
  localparam logic [7:0]  ERR_NONE       = 8'h00;
  localparam int unsigned MSG_TIME_MS    = 1;    // Brief message duration
  localparam int unsigned CLK_HZ         = 50000000;
  localparam int unsigned MSG_CYCLES     = MSG_TIME_MS * (CLK_HZ / 1000);
  localparam logic [2:0]  TYPE_NONE      = 3'h0; // Module type codes
  localparam logic [2:0]  TYPE_MEAS      = 3'h1;
  localparam logic [2:0]  TYPE_NONMEAS   = 3'h2;

  // Relay bank image, one bit per relay, bit 0 is relay 1
  typedef logic [NUM_RELAYS-1:0] rcs_bank_t;

  // Selected channel: slot index and channel number, zero means none
  typedef struct packed {
    logic       slot;
    logic [4:0] chan;
  } rcs_chan_s;

  // Remote request group
  typedef struct packed {
    logic       close;
    logic       open_all;
    logic       assign_virt;
    logic [3:0] digit_slot;
    logic [7:0] digit_chan; // Two BCD digits
    logic [2:0] virt_type;
  } rcs_req_s;
endpackage : rcs_pkg

// ### verilog/rcs_selector.sv
// Relay channel selector: system channel control for two switching slots
// Contract
// R1 - At most one system channel; none when nothing is shown.
// R2 - Closing a channel closes input isolation; 4-wire adds pair and sense.
// R3 - Open previous system channel and pair before closing the new one.
// R4 - Only meter-routable measurement channels may become system channel.
// R5 - Channels are addressed by slot digit plus two channel digits.
// R6 - Twenty-channel module: channels 1-10 system, channel n pairs n+10.
// R7 - 2-wire select closes channel relay and input isolation relay 25.
// R8 - 4-wire select also closes paired relay and sense isolation 24.
// R9 - 4-wire select also closes pole-mode relay 23.
// R10 - Step keys move to next or previous valid channel, open then close.
// R11 - Step with no module in either slot flags no-module briefly.
// R12 - Step with no measuring module flags no-measuring-module briefly.
// R13 - Stepping past the range ends shows nothing and opens everything.
// R14 - Virtual module assigned only to empty slot, only remotely.
// R15 - Virtual module behaves exactly like a fitted module.
// R16 - Virtual assignments are volatile, lost at power removal.
// R17 - System channel number is shown; paired channel is not.
// R18 - Remote close of invalid channel returns out-of-range error.
// R19 - Open-all opens every relay on all modules.
// R20 - Module present and type inputs decide valid channels.
`timescale 1ns/1ps
module rcs_selector (
  // Clock and reset
  input  wire logic               clk_in,
  input  wire logic               rst_in,
  // Module detection pins
  input  wire logic [1:0]         present_in,
  input  wire logic [5:0]         type_in,
  // Front panel
  input  wire logic               key_next_in,
  input  wire logic               key_prev_in,
  input  wire logic               four_wire_in,
  // Remote requests (same clock domain)
  input  wire rcs_pkg::rcs_req_s  req_in,
  input  wire logic               req_remote_in,
  // Relay coils
  output rcs_pkg::rcs_bank_t      relay0_out,
  output rcs_pkg::rcs_bank_t      relay1_out,
  // Status
  output rcs_pkg::rcs_chan_s      shown_out,
  output logic                    shown_valid_out,
  output logic                    no_module_out,
  output logic                    no_measuring_module_indication_out,
  output logic [7:0]              error_code_out,
  output logic                    done_out
);
  import rcs_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_OPEN  = 2'b01,
    ST_CLOSE = 2'b10
  } rcs_state_e;

  rcs_state_e  state_reg;
  logic [1:0]  pres_s1_reg, pres_s2_reg;
  logic [5:0]  type_s1_reg, type_s2_reg;
  logic [1:0]  next_s1_reg, next_s2_reg, prev_s1_reg, prev_s2_reg;
  logic        next_d_reg, prev_d_reg;
  logic [5:0]  virt_reg;              // Virtual type per slot
  rcs_chan_s   sys_reg, target_reg;
  logic        sys_valid_reg, target_valid_reg, sys_4w_reg;
  rcs_bank_t   bank_reg [NUM_SLOTS];
  logic [7:0]  err_reg;
  logic        done_reg;
  logic        msg_nomod_start, msg_nomeas_start;
  logic        code_ok;
  rcs_chan_s   code_chan;
  logic        next_p, prev_p;
  logic [2:0]  eff_type [NUM_SLOTS];
  logic        any_mod, any_meas;
  rcs_chan_s   step_chan;
  logic        step_valid;

  // Synchronise pin inputs; first stage feeds only the second
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pres_s1_reg <= 2'h0;
      pres_s2_reg <= 2'h0;
      type_s1_reg <= 6'h00;
      type_s2_reg <= 6'h00;
      next_s1_reg <= 2'h0;
      next_s2_reg <= 2'h0;
      prev_s1_reg <= 2'h0;
      prev_s2_reg <= 2'h0;
    end else begin
      pres_s1_reg <= present_in;
      pres_s2_reg <= pres_s1_reg;
      type_s1_reg <= type_in;
      type_s2_reg <= type_s1_reg;
      next_s1_reg <= {next_s1_reg[0], key_next_in};
      next_s2_reg <= {next_s2_reg[0], next_s1_reg[1]};
      prev_s1_reg <= {prev_s1_reg[0], key_prev_in};
      prev_s2_reg <= {prev_s2_reg[0], prev_s1_reg[1]};
    end
  end

  // Key edge detectors on the synchronised level
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      next_d_reg <= 1'b0;
      prev_d_reg <= 1'b0;
    end else begin
      next_d_reg <= next_s2_reg[0];
      prev_d_reg <= prev_s2_reg[0];
    end
  end
  assign next_p = next_s2_reg[0] & ~next_d_reg;
  assign prev_p = prev_s2_reg[0] & ~prev_d_reg;

  // Effective module type: fitted wins, else virtual
  always_comb begin
    for (int s = 0; s < NUM_SLOTS; s++) begin
      eff_type[s] = pres_s2_reg[s] ? type_s2_reg[3*s +: 3]
                                   : virt_reg[3*s +: 3]; // [R15] [R20]
    end
    any_mod  = (eff_type[0] != TYPE_NONE) || (eff_type[1] != TYPE_NONE);
    any_meas = (eff_type[0] == TYPE_MEAS) || (eff_type[1] == TYPE_MEAS);
  end

  // Valid system channel on current wiring mode
  function automatic logic is_meas(input rcs_chan_s c, input logic fw,
                                   input logic [2:0] t0, input logic [2:0] t1);
    logic [2:0] t;
    t = c.slot ? t1 : t0;
    is_meas = (t == TYPE_MEAS) && c.chan != 5'h00 &&
              c.chan <= (fw ? 5'(SYS_CH_MAX) : 5'(MEAS_CH)); // [R4] [R6]
  endfunction : is_meas

  // Linear position 1..40 of a channel for stepping
  function automatic logic [5:0] lin(input rcs_chan_s c);
    lin = {1'b0, c.chan} + (c.slot ? 6'(MEAS_CH) : 6'h00);
  endfunction : lin

  // Next or previous valid channel; none when past an end
  always_comb begin
    logic [5:0] pos;
    rcs_chan_s  c;
    c = '0;
    pos = sys_valid_reg ? lin(sys_reg) : 6'h00;
    step_chan = '0;
    step_valid = 1'b0;
    if (next_p) begin
      for (int i = 40; i >= 1; i--) begin
        c.slot = (i > 20);
        c.chan = 5'(i > 20 ? i - 20 : i);
        if (6'(i) > pos && is_meas(c, four_wire_in, eff_type[0],
                                    eff_type[1])) begin
          step_chan = c;
          step_valid = 1'b1;
        end
      end
    end else begin
      for (int i = 1; i <= 40; i++) begin
        c.slot = (i > 20);
        c.chan = 5'(i > 20 ? i - 20 : i);
        if ((pos == 6'h00 || 6'(i) < pos) &&
            is_meas(c, four_wire_in, eff_type[0], eff_type[1])) begin
          step_chan = c;
          step_valid = 1'b1;
        end
      end
    end
  end

  rcs_code_decode u_decode (
    .slot_digit_in (req_in.digit_slot),
    .chan_bcd_in   (req_in.digit_chan),
    .ok_out        (code_ok),
    .chan_out      (code_chan)
  );

  // Sequencer: take a request, open old channel, then close new one
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_reg        <= ST_IDLE;
      sys_reg          <= '0;
      sys_valid_reg    <= 1'b0;
      sys_4w_reg       <= 1'b0;
      target_reg       <= '0;
      target_valid_reg <= 1'b0;
      err_reg          <= ERR_NONE;
      done_reg         <= 1'b0;
      for (int s = 0; s < NUM_SLOTS; s++) bank_reg[s] <= '0;
    end else begin
      done_reg <= 1'b0;
      unique case (state_reg)
        ST_IDLE: begin
          if (req_remote_in && req_in.open_all) begin
            for (int s = 0; s < NUM_SLOTS; s++) bank_reg[s] <= '0; // [R19]
            sys_valid_reg <= 1'b0;
            err_reg <= ERR_NONE;
            done_reg <= 1'b1;
          end else if (req_remote_in && req_in.close) begin
            if (code_ok && is_meas(code_chan, four_wire_in,
                                   eff_type[0], eff_type[1])) begin
              target_reg <= code_chan;
              target_valid_reg <= 1'b1;
              err_reg <= ERR_NONE;
              state_reg <= ST_OPEN;
            end else begin
              err_reg <= ERR_RANGE; // [R18]
              done_reg <= 1'b1;
            end
          end else if ((next_p || prev_p) && any_meas) begin
            target_reg <= step_chan; // [R10]
            target_valid_reg <= step_valid; // [R13]
            state_reg <= ST_OPEN;
          end
        end
        ST_OPEN: begin
          // Old channel and its pair leave first to avoid two on the bus
          if (sys_valid_reg) begin
            bank_reg[sys_reg.slot][sys_reg.chan - 5'h01] <= 1'b0; // [R3]
            if (sys_4w_reg) begin
              bank_reg[sys_reg.slot][sys_reg.chan + 5'(PAIR_OFFSET) - 5'h01]
                <= 1'b0;
            end
            // Routing relays leave with the channel, so a 2-wire or
            // other-slot pick never keeps stale sense or pole paths; a
            // same-slot pick opens input isolation for one cycle
            bank_reg[sys_reg.slot][INPUT_ISO - 5'h01]  <= 1'b0; // [R3]
            bank_reg[sys_reg.slot][SENSE_ISO - 5'h01]  <= 1'b0;
            bank_reg[sys_reg.slot][POLE_RELAY - 5'h01] <= 1'b0;
          end
          if (!target_valid_reg) begin
            for (int s = 0; s < NUM_SLOTS; s++) bank_reg[s] <= '0; // [R13]
          end
          sys_valid_reg <= 1'b0;
          state_reg <= ST_CLOSE;
        end
        ST_CLOSE: begin
          if (target_valid_reg) begin
            bank_reg[target_reg.slot][target_reg.chan - 5'h01] <= 1'b1;
            bank_reg[target_reg.slot][INPUT_ISO - 5'h01] <= 1'b1; // [R2] [R7]
            if (four_wire_in) begin
              bank_reg[target_reg.slot]
                [target_reg.chan + 5'(PAIR_OFFSET) - 5'h01] <= 1'b1; // [R8]
              bank_reg[target_reg.slot][SENSE_ISO - 5'h01] <= 1'b1; // [R8]
              bank_reg[target_reg.slot][POLE_RELAY - 5'h01] <= 1'b1; // [R9]
            end
            sys_reg <= target_reg; // [R1]
            sys_valid_reg <= 1'b1;
            sys_4w_reg <= four_wire_in;
          end
          done_reg <= 1'b1;
          state_reg <= ST_IDLE;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Virtual modules: remote only, empty slot only; reset models power loss
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      virt_reg <= 6'h00; // [R16]
    end else if (req_remote_in && req_in.assign_virt &&
                 code_ok && !pres_s2_reg[code_chan.slot]) begin
      virt_reg[3*code_chan.slot +: 3] <= req_in.virt_type; // [R14]
    end
  end

  assign msg_nomod_start  = (next_p || prev_p) && !any_mod; // [R11]
  assign msg_nomeas_start = (next_p || prev_p) && any_mod && !any_meas; // [R12]

  rcs_msg_timer u_nomod (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .start_in (msg_nomod_start),
    .busy_out (no_module_out)
  );
  rcs_msg_timer u_nomeas (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .start_in (msg_nomeas_start),
    .busy_out (no_measuring_module_indication_out)
  );

  // Only the system channel is shown, never its pair
  assign shown_out       = sys_valid_reg ? sys_reg : '0; // [R17]
  assign shown_valid_out = sys_valid_reg; // [R1]
  assign relay0_out      = bank_reg[0];
  assign relay1_out      = bank_reg[1];
  assign error_code_out  = err_reg;
  assign done_out        = done_reg;

  AST_ISO_WITH_CH: assert property (@(posedge clk_in) disable iff (rst_in)
    sys_valid_reg |-> bank_reg[sys_reg.slot][INPUT_ISO - 5'h01]) // [R2]
    else $error("Input isolation open with system channel");
  AST_POLE_4W: assert property (@(posedge clk_in) disable iff (rst_in)
    (sys_valid_reg && sys_4w_reg) |->
      bank_reg[sys_reg.slot][POLE_RELAY - 5'h01] &&
      bank_reg[sys_reg.slot][SENSE_ISO - 5'h01]) // [R9]
    else $error("Pole or sense relay open in 4-wire");
  AST_OPEN_FIRST: assert property (@(posedge clk_in) disable iff (rst_in)
    state_reg == ST_OPEN |=> !sys_valid_reg) // [R3]
    else $error("Old channel not released before close");
  AST_BAD_CLOSE: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_reg == ST_IDLE && req_remote_in && req_in.close && !req_in.open_all
     && !code_ok) |=> err_reg == ERR_RANGE && done_reg) // [R18]
    else $error("Invalid close not rejected");
  AST_OPEN_ALL: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_reg == ST_IDLE && req_remote_in && req_in.open_all) |=>
      relay0_out == '0 && relay1_out == '0 && !shown_valid_out) // [R19]
    else $error("Open-all left a relay closed");
  AST_SEQ_LEN: assert property (@(posedge clk_in) disable iff (rst_in)
    state_reg == ST_OPEN |=> state_reg == ST_CLOSE ##1 done_reg) // [R10]
    else $error("Selection sequence length wrong");
  AST_NOMOD: assert property (@(posedge clk_in) disable iff (rst_in)
    msg_nomod_start |-> ##2 no_module_out) // [R11]
    else $error("No-module indication missing");
  AST_NOMEAS: assert property (@(posedge clk_in) disable iff (rst_in)
    (msg_nomeas_start && state_reg == ST_IDLE) |=>
      state_reg == ST_IDLE) // [R12]
    else $error("Selection started with no measuring module");
  AST_EMPTY_OPEN: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_reg == ST_OPEN && !target_valid_reg) |=>
      relay0_out == '0 && relay1_out == '0) // [R13]
    else $error("Stepping off the end left relays closed");

  COV_STEP: cover property (@(posedge clk_in) next_p && any_meas);
  COV_4W: cover property (@(posedge clk_in) sys_valid_reg && sys_4w_reg);
  COV_ERR: cover property (@(posedge clk_in) err_reg == ERR_RANGE);
  COV_VIRT: cover property (@(posedge clk_in) virt_reg != 6'h00);
endmodule : rcs_selector
